/* rtl/clk_sel_pkg.sv */
// Purpose: Shared constants for the double speed clock selection block
// Assumes: One 32-bit APB slave port, pclk stands for the crystal input
// Notes:   Register byte address is four times the register index
package clk_sel_pkg;

	// Register indices and byte addresses
	localparam int           ADDR_W    = 12;
	localparam logic [7:0]   CTRL_IDX  = 8'h8F;
	localparam logic [7:0]   STAT_IDX  = 8'h90;
	localparam logic [11:0]  CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
	localparam logic [11:0]  STAT_ADDR = {2'h0, STAT_IDX, 2'h0};

	// Control register layout
	localparam int           N_PERIPH    = 6;
	localparam int           CTRL_W      = N_PERIPH + 1;
	localparam int           CPU_BIT     = 0;
	localparam int           PERIPH_BASE = 1;
	localparam logic [6:0]   CTRL_RESET  = 7'h00;

	// Peripheral channel order inside the select field
	localparam int           TIMER_ZERO_CH    = 0;
	localparam int           TIMER_ONE_CH     = 1;
	localparam int           TIMER_TWO_CH     = 2;
	localparam int           SERIAL_PORT_CH   = 3;
	localparam int           COUNTER_ARRAY_CH = 4;
	localparam int           WATCHDOG_CH      = 5;

	// Status register layout
	localparam int           STAT_HALF_BIT = 7;

	// Cycle counts
	localparam int           STD_PERIODS      = 12;
	localparam int           DBL_PERIODS      = 6;
	localparam int           PHASES_PER_CYCLE = STD_PERIODS / 2;

	// Channel mode
	typedef enum logic
	{
		STANDARD_SPEED_MODE,
		DOUBLE_SPEED_MODE
	} speed_mode_type;

endpackage

/* rtl/speed_divider.sv */
// Purpose: Phase clock enable and machine cycle marker for one channel
// Assumes: src_en is the phase clock of the channel, one pclk wide pulses or held high in double speed
// Notes:   Both outputs are registered and lag src_en by one pclk
`timescale 1ns/100ps
module speed_divider
	import clk_sel_pkg::*;
#(
	parameter int PHASES = PHASES_PER_CYCLE
)
(
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Phase source
	input  wire logic src_en,
	// Enables out
	output logic      clk_en,
	output logic      cycle_end
);

	localparam int CW = $clog2(PHASES);
	localparam logic [CW-1:0] LAST = CW'(PHASES - 1);

	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	wire           at_last;

	// Machine cycle spans a fixed number of phases, so the time base
	// follows the phase rate of the channel
	assign at_last = (cnt_r >= LAST);
	assign cnt_nxt = !src_en ? cnt_r : (at_last ? '0 : cnt_r + 1'b1);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_r     <= '0;
			clk_en    <= 1'b0;
			cycle_end <= 1'b0;
		end
		else
		begin
			cnt_r     <= cnt_nxt;
			clk_en    <= src_en;
			cycle_end <= src_en & at_last;
		end
	end

endmodule

/* rtl/double_speed_clock_select.sv */
// Purpose: CPU and peripheral clock enables with double speed selection
// Assumes: pclk is the crystal input; APB master follows APB rules
// Notes:   Select bits take effect on the halved clock rise only
// Function
// - Double speed: machine cycle of 6 periods
// - Standard: divide-by-two before phase generator
// - Double speed: core runs from crystal directly
// - Select bit chooses 12 or 6 periods
// - Reset gives standard speed unless option set
// - Security option starts in double speed
// - Select bit changes CPU clock and following peripherals
// - Peripheral follows CPU when its bit clear
// - Speed change applied on halved clock rise
// - Double speed peripheral time base halves
// - Peripheral bit: clear 6, set 12 periods
// - Peripheral bits only matter in double speed
// - Control resets cleared, top bit reads zero
`timescale 1ns/100ps
module double_speed_clock_select
	import clk_sel_pkg::*;
(
	// Clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// Nonvolatile option strap
	input  wire logic                start_double_speed_option,
	// APB slave
	input  wire logic [ADDR_W-1:0]   paddr,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// Clock enables
	output logic                     half_clk,
	output logic                     cpu_clk_en,
	output logic                     cpu_cycle_end,
	output logic                     cpu_double_active,
	output logic      [N_PERIPH-1:0] periph_clk_en,
	output logic      [N_PERIPH-1:0] periph_cycle_end
);

	logic              init_done_r;
	logic [CTRL_W-1:0] clock_speed_control_reg;
	logic [CTRL_W-1:0] ctrl_nxt;
	logic [CTRL_W-1:0] app_r;
	logic [CTRL_W-1:0] app_nxt;
	logic              half_r;
	logic              pready_r;
	logic [31:0]       prdata_r;
	logic              pslverr_r;
	logic              dbl_r;

	wire               setup_ph;
	wire               access_ph;
	wire               ctrl_hit;
	wire               stat_hit;
	wire               bad_acc;
	wire               wr_go;
	wire [31:0]        rd_data;
	wire [31:0]        ctrl_word;
	wire [31:0]        stat_word;
	wire               half_rise;
	wire [CTRL_W-1:0]  ch_dbl;
	wire [CTRL_W-1:0]  ch_src;
	wire [CTRL_W-1:0]  ch_clk;
	wire [CTRL_W-1:0]  ch_cyc;
	wire               cpu_double_speed_select;
	speed_mode_type    cpu_mode;

	// APB decode
	assign setup_ph  = psel & ~penable;
	assign access_ph = psel & penable & pready_r;
	assign ctrl_hit  = (paddr == CTRL_ADDR);
	assign stat_hit  = (paddr == STAT_ADDR) & ~pwrite;
	assign bad_acc   = ~(ctrl_hit | stat_hit);
	assign wr_go     = access_ph & pwrite & ctrl_hit;

	// Reserved top bit and upper word read as zero
	assign ctrl_word = {{(32-CTRL_W){1'b0}},
		clock_speed_control_reg};
	// Status: halved clock level just above the applied select bits
	assign stat_word = {{(31-CTRL_W){1'b0}}, half_r, app_r};
	assign rd_data   = ctrl_hit ? ctrl_word :
		stat_hit ? stat_word : 32'h00000000;

	// Software may switch in either direction; top bit cannot be set
	assign ctrl_nxt = !init_done_r ?
		{{(CTRL_W-1){1'b0}}, start_double_speed_option} :
		wr_go ? pwdata[CTRL_W-1:0] :
		clock_speed_control_reg;

	// Select bits take effect only where the halved clock rises
	assign half_rise = ~half_r;
	assign app_nxt   = half_rise ? clock_speed_control_reg : app_r;

	// Channel 0 is the CPU, channels 1 up are the peripherals
	assign cpu_double_speed_select = app_r[CPU_BIT];
	assign ch_dbl[CPU_BIT] = cpu_double_speed_select;
	assign cpu_mode = cpu_double_speed_select ?
		DOUBLE_SPEED_MODE : STANDARD_SPEED_MODE;

	genvar gi;
	generate
		for (gi = 0; gi < N_PERIPH; gi++)
		begin : g_periph
			// Follow the CPU only when the own bit is clear
			assign ch_dbl[PERIPH_BASE+gi] = cpu_double_speed_select &
				~app_r[PERIPH_BASE+gi];
		end
		for (gi = 0; gi < CTRL_W; gi++)
		begin : g_chan
			// Double speed bypasses the divide-by-two stage
			assign ch_src[gi] = ch_dbl[gi] ? 1'b1 : half_rise;
			speed_divider #(
				.PHASES    (PHASES_PER_CYCLE)
			) u_div (
				.pclk      (pclk),
				.presetn   (presetn),
				.src_en    (ch_src[gi]),
				.clk_en    (ch_clk[gi]),
				.cycle_end (ch_cyc[gi])
			);
		end
	endgenerate

	// Strap is caught on the first edge after reset release
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			init_done_r             <= 1'b0;
			clock_speed_control_reg <= CTRL_RESET;
			app_r                   <= CTRL_RESET;
			half_r                  <= 1'b0;
		end
		else
		begin
			init_done_r             <= 1'b1;
			clock_speed_control_reg <= ctrl_nxt;
			app_r                   <= app_nxt;
			half_r                  <= ~half_r;
		end
	end

	// APB answer: one access cycle, no wait states
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_r  <= 1'b0;
			prdata_r  <= 32'h00000000;
			pslverr_r <= 1'b0;
			dbl_r     <= 1'b0;
		end
		else
		begin
			pready_r  <= setup_ph;
			prdata_r  <= setup_ph ? rd_data : prdata_r;
			pslverr_r <= setup_ph & bad_acc;
			dbl_r     <= (cpu_mode == DOUBLE_SPEED_MODE);
		end
	end

	assign prdata            = prdata_r;
	assign pready            = pready_r;
	assign pslverr           = pslverr_r;
	assign half_clk          = half_r;
	assign cpu_double_active = dbl_r;
	assign cpu_clk_en        = ch_clk[CPU_BIT];
	assign cpu_cycle_end     = ch_cyc[CPU_BIT];
	assign periph_clk_en     = ch_clk[CTRL_W-1:PERIPH_BASE];
	assign periph_cycle_end  = ch_cyc[CTRL_W-1:PERIPH_BASE];

	// Helper logic: pclk count between CPU machine cycle markers
	logic [4:0] gap_r;
	logic       clean_r;
	logic       seen_r;
	logic       app_q;
	wire        cpu_chg;

	assign cpu_chg = app_q ^ app_r[CPU_BIT];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gap_r   <= 5'h00;
			clean_r <= 1'b0;
			seen_r  <= 1'b0;
			app_q   <= 1'b0;
		end
		else
		begin
			app_q   <= app_r[CPU_BIT];
			gap_r   <= cpu_cycle_end ? 5'h00 : gap_r + 5'h01;
			seen_r  <= seen_r | cpu_cycle_end;
			clean_r <= cpu_cycle_end ? ~cpu_chg : clean_r & ~cpu_chg;
		end
	end

	// Machine cycle length follows the applied CPU mode
	cpu_cycle_len_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(cpu_cycle_end && clean_r && seen_r && !cpu_chg) |->
		(6'(gap_r) + 6'h01 == (app_q ? 6'(DBL_PERIODS) : 6'(STD_PERIODS))))
		else $error("CPU machine cycle length wrong");

	// Standard mode never gives two phase enables in a row
	std_half_rate_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(!app_r[CPU_BIT] && !app_q && cpu_clk_en) |=> !cpu_clk_en)
		else $error("CPU phase not halved in standard mode");

	// Double speed gives a phase enable on every crystal period
	dbl_bypass_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		app_r[CPU_BIT] |=> cpu_clk_en)
		else $error("CPU phase missing in double speed");

	// A write lands in the control register, reserved bit dropped
	ctrl_write_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_go |=> (clock_speed_control_reg == $past(pwdata[CTRL_W-1:0])))
		else $error("Control register write lost");

	// After release the option alone decides the start mode
	reset_opt_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(init_done_r) |->
		(clock_speed_control_reg == {{(CTRL_W-1){1'b0}},
		$past(start_double_speed_option)}))
		else $error("Start mode not taken from option");

	// Control read shows zero in the reserved top bit
	reserved_read_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(setup_ph && ctrl_hit) |=> (prdata[31:CTRL_W] == '0))
		else $error("Reserved control bits not zero");

	// Mode changes only where the halved clock has just risen
	glitch_free_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(app_r != $past(app_r)) |-> (half_r && !$past(half_r)))
		else $error("Mode applied off the halved clock rise");

	// With the CPU in standard mode no peripheral runs fast
	std_periph_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(!app_r[CPU_BIT] && !app_q) |->
		((periph_clk_en & $past(periph_clk_en)) == '0))
		else $error("Peripheral fast while CPU in standard");

	// Cleared peripheral bit follows the CPU into double speed
	follow_cpu_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(app_r[CPU_BIT] && !app_r[PERIPH_BASE+WATCHDOG_CH]) |=>
		periph_clk_en[WATCHDOG_CH])
		else $error("Watchdog did not follow double speed");

	// Set peripheral bit keeps the divided clock
	stay_divided_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(app_r[PERIPH_BASE+TIMER_ZERO_CH] &&
		$past(app_r[PERIPH_BASE+TIMER_ZERO_CH]) &&
		periph_clk_en[TIMER_ZERO_CH]) |=> !periph_clk_en[TIMER_ZERO_CH])
		else $error("Timer zero left the divided clock");

	// Every setup cycle gets one answer cycle, error flag by address
	apb_answer_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		setup_ph |=> (pready && (pslverr == $past(bad_acc))) ##1 !pready)
		else $error("Register bus answer wrong");

	// Control register keeps its value unless written
	ctrl_hold_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(init_done_r && !wr_go) |=> $stable(clock_speed_control_reg))
		else $error("Control register changed without write");

	// Read data holds between setup cycles
	prdata_hold_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!setup_ph |=> $stable(prdata))
		else $error("Read data changed outside a setup");

	// Status read shows applied bits, halved clock and zero above
	status_read_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(setup_ph && stat_hit) |=>
		(prdata[CTRL_W-1:0] == $past(app_r) &&
		prdata[STAT_HALF_BIT] == $past(half_r) &&
		prdata[31:STAT_HALF_BIT+1] == '0))
		else $error("Status read wrong");

	// Flag output trails the applied CPU mode by one cycle
	double_flag_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		cpu_double_active == $past(app_r[CPU_BIT]))
		else $error("Double speed flag wrong");

	// A machine cycle ends only on a phase enable
	cycle_phase_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		cpu_cycle_end |-> cpu_clk_en)
		else $error("CPU cycle end without phase");

	// Same for every peripheral channel
	periph_phase_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(periph_cycle_end & ~periph_clk_en) == '0)
		else $error("Peripheral cycle end without phase");

	// The halved clock toggles on every crystal period
	half_toggle_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		init_done_r |-> (half_r != $past(half_r)))
		else $error("Halved clock did not toggle");

	// Serial port follows the CPU into double speed
	follow_serial_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(app_r[CPU_BIT] && !app_r[PERIPH_BASE+SERIAL_PORT_CH]) |=>
		periph_clk_en[SERIAL_PORT_CH])
		else $error("Serial port did not follow double speed");

	// Nothing is applied before the first halved clock rise
	reset_apply_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(init_done_r) |-> (app_r == CTRL_RESET))
		else $error("Applied bits not cleared after reset");

	// Main scenarios
	to_double_c: cover property (
		@(posedge pclk) disable iff (!presetn)
		$rose(app_r[CPU_BIT]));
	to_standard_c: cover property (
		@(posedge pclk) disable iff (!presetn)
		$fell(app_r[CPU_BIT]));
	periph_fast_c: cover property (
		@(posedge pclk) disable iff (!presetn)
		periph_cycle_end[SERIAL_PORT_CH] && app_r[CPU_BIT] &&
		!app_r[PERIPH_BASE+SERIAL_PORT_CH]);
	bad_addr_c: cover property (
		@(posedge pclk) disable iff (!presetn)
		pslverr && pready);
	dbl_start_c: cover property (
		@(posedge pclk) disable iff (!presetn)
		$rose(init_done_r) && clock_speed_control_reg[CPU_BIT]);

endmodule

/* verif/crystal_source.sv */
// Purpose: Crystal or external clock source driving the block
// Assumes: Free running oscillator, even duty cycle
// Notes:   Half period is a parameter in ns
`timescale 1ns/100ps
module crystal_source
#(
	parameter real HALF_NS = 2.0
)
(
	// Oscillator output
	output logic crystal_input
);
	initial
	begin
		crystal_input = 1'b0;
		forever
		begin
			#(HALF_NS) crystal_input = ~crystal_input;
		end
	end
endmodule

/* verif/testbench.sv */
// Purpose: Self-checking bench for the double speed clock selection block
// Assumes: APB master with zero wait state slave, one clock domain
// Notes:   Read results are queued at setup and checked by a monitor
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
	$display("ERROR %s exp %0h got %0h", nm, e, g); end end
module testbench
	import clk_sel_pkg::*;
;
	logic                pclk;
	logic                presetn;
	logic                strap;
	logic [ADDR_W-1:0]   paddr;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic [31:0]         pwdata;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	logic                half_clk;
	logic                cpu_clk_en;
	logic                cpu_cycle_end;
	logic                cpu_double_active;
	logic [N_PERIPH-1:0] periph_clk_en;
	logic [N_PERIPH-1:0] periph_cycle_end;
	wire  [6:0]          ends = {periph_cycle_end, cpu_cycle_end};
	wire  [6:0]          ens  = {periph_clk_en, cpu_clk_en};
	logic                h;
	int                  m;
	int                  want;
	logic [33:0]         exp_q[$];
	logic [33:0]         e;
	logic [7:0]          vals[4];
	logic [7:0]          v;
	int                  n_fail;
	int                  compares;
	int                  seed;
	int                  n;

	crystal_source xtal (.crystal_input(pclk));

	double_speed_clock_select dut (
		.pclk(pclk), .presetn(presetn), .start_double_speed_option(strap),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .half_clk(half_clk), .cpu_clk_en(cpu_clk_en),
		.cpu_cycle_end(cpu_cycle_end),
		.cpu_double_active(cpu_double_active),
		.periph_clk_en(periph_clk_en), .periph_cycle_end(periph_cycle_end));

	task print_verdict;
		if (n_fail == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Expectation word: {check data, error, data}
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [33:0] x);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		exp_q.push_back(x);
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Count pclk and phases between two cycle ends, after one settling cycle
	task per(input int ch, output int c, output int q);
		int k;
		k = 0;
		c = 0;
		q = 0;
		repeat (2)
		begin
			do
			begin
				@(posedge pclk);
				k++;
			end
			while (ends[ch] !== 1'b1 && k < 100);
		end
		do
		begin
			@(posedge pclk);
			c++;
			q += ens[ch];
		end
		while (ends[ch] !== 1'b1 && c < 100);
	endtask

	always @(posedge pclk)
	begin
		if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
		begin
			e = exp_q.pop_front();
			`CHK("pslverr", e[32], pslverr)
			if (e[33])
				`CHK("prdata", e[31:0], prdata)
		end
	end

	initial
	begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		print_verdict();
	end

	initial
	begin
		presetn = 1'b0;
		strap   = 1'b0;
		paddr   = '0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		pwdata  = '0;
		n_fail  = 0;
		compares = 0;
		seed    = 32'h85AD;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		apb(1'b0, CTRL_ADDR, 32'h0, 34'h200000000);
		per(0, n, m);
		`CHK("cpu period", STD_PERIODS, n)
		h = half_clk;
		@(posedge pclk);
		`CHK("half clk", !h, half_clk)
		v = 8'($random(seed));
		vals = '{8'h01, 8'hFF, v | 8'h01, v & 8'hFE};
		foreach (vals[i])
		begin
			apb(1'b1, CTRL_ADDR, {24'($random(seed)), vals[i]}, 34'h0);
			apb(1'b0, CTRL_ADDR, 32'h0,
				{2'h2, 25'h0, vals[i][6:0]});
			per(0, n, m);
			`CHK("cpu period", vals[i][0] ? 6 : 12, n)
			`CHK("cpu phases", PHASES_PER_CYCLE, m)
			`CHK("cpu double", vals[i][0], cpu_double_active)
			for (int p = 1; p <= N_PERIPH; p++)
			begin
				per(p, n, m);
				want = (vals[i][0] && !vals[i][p]) ? 6 : 12;
				`CHK("periph period", want, n)
				`CHK("periph phases", PHASES_PER_CYCLE, m)
			end
			apb(1'b0, STAT_ADDR, 32'h0,
				{2'h2, 24'h0, half_clk, vals[i][6:0]});
		end
		apb(1'b1, 12'h000, 32'hFF, 34'h100000000);
		apb(1'b0, 12'h004, 32'h0, 34'h100000000);
		apb(1'b1, STAT_ADDR, 32'h7F, 34'h100000000);
		apb(1'b0, CTRL_ADDR, 32'h0, {2'h2, 25'h0, vals[3][6:0]});
		@(posedge pclk);
		presetn <= 1'b0;
		strap   <= 1'b1;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		apb(1'b0, CTRL_ADDR, 32'h0, 34'h200000001);
		per(0, n, m);
		`CHK("cpu period", DBL_PERIODS, n)
		`CHK("cpu double", 1'b1, cpu_double_active)
		repeat (2) @(posedge pclk);
		`CHK("queue empty", 0, exp_q.size())
		print_verdict();
	end
endmodule
